// ---- common/fuid_pkg.sv ----
// Constants shared by the flash identification responder and its host controller.
// Assumes SPI mode 0 framing with a single data line in each direction.
package fuid_pkg;
  localparam logic [7:0]   UNIQUE_ID_READ_CMD       = 8'h4b;
  localparam logic [7:0]   DISCOVERY_TABLE_READ_CMD = 8'h5a;
  localparam int           UID_DUMMY_BYTES          = 4;
  localparam int           DISC_ADDR_BYTES          = 3;
  localparam int           DISC_DUMMY_BYTES         = 1;
  localparam int           UID_BITS                 = 128;
  // Arbitrary neutral values; real parts program their own
  localparam logic [127:0] UID_DEFAULT              = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  localparam logic [7:0]   MAKER_CODE_DEFAULT       = 8'h5c;
  // Array density in bits minus one, 32 Mbit
  localparam logic [31:0]  DENSITY_BITS_M1          = 32'h01ff_ffff;
  localparam logic [23:0]  STD_TABLE_PTR            = 24'h00_0030;
  localparam logic [23:0]  VENDOR_TABLE_PTR         = 24'h00_0060;
  localparam logic [7:0]   STD_TABLE_DWORDS         = 8'h09;
  localparam logic [7:0]   VENDOR_TABLE_DWORDS      = 8'h03;
  localparam logic [7:0]   UNUSED_BYTE              = 8'hff;
  // APB register map of the host controller
  localparam logic [7:0]   REG_CTRL                 = 8'h00;
  localparam logic [7:0]   REG_ADDR                 = 8'h04;
  localparam logic [7:0]   REG_STATUS               = 8'h08;
  localparam logic [7:0]   REG_DATA0                = 8'h10;
  localparam int           CTRL_START_BIT           = 0;
  localparam int           CTRL_MODE_BIT            = 1;
  localparam int           CTRL_LEN_LSB             = 8;
  localparam int           STATUS_BUSY_BIT          = 0;
  localparam int           STATUS_DONE_BIT          = 1;
  localparam int           SCK_HALF_DIV             = 2;
  localparam int           MAX_READ_BYTES           = 16;
endpackage

// ---- common/fuid_if.sv ----
// Serial link between flash identification responder and host controller.
// The host qualifies the output line with its enable.
`timescale 1ns/1ns
interface fuid_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev  (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface

// ---- src/fuid_dev.sv ----
// Flash identification responder: unique id and discovery table reads.
// Runs on the serial clock; chip select high acts as its reset.
// Only single-line mode 0 framing is decoded; wide and quad modes are not.
//
// Behaviour
// - Opcode 4BH starts unique id readout
// - Four dummy bytes, then 128 id bits
// - Identifier is fixed and unalterable
// - Host sends 5AH plus three address bytes
// - One dummy byte, then table bytes out
// - Chip select high stops output anytime
// - Bytes 00H-03H read signature 53 46 44 50
// - Revision bytes 04H=00H, 05H=01H
// - Byte 06H reads header count 01H
// - Bytes 07H, 0FH, 17H read FFH
// - First header id 00H, revisions 00H/01H
// - First header length 09H, pointer 30H
// - Second header maker code, length 03H, pointer 60H
// - Byte 30H E5H, byte 31H 20H
// - Byte 32H F1H, byte 33H FFH
// - Byte 38H 44H, byte 39H EBH
// - Byte 3AH 08H, byte 3BH 6BH
`timescale 1ns/1ns
module fuid_dev #(
  parameter logic [127:0] UNIQUE_ID  = fuid_pkg::UID_DEFAULT,
  parameter logic [7:0]   MAKER_CODE = fuid_pkg::MAKER_CODE_DEFAULT
) (
  // Serial link
  fuid_if.dev link
);
  typedef enum {FUID_CMD, FUID_ADDR, FUID_DUMMY, FUID_DATA, FUID_IGNORE} fuid_state_t;

  fuid_state_t state;
  logic [2:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic [1:0]  byte_cnt;
  logic        is_uid;
  logic [23:0] tbl_addr;
  logic [7:0]  out_byte;
  logic [6:0]  uid_idx;
  logic        so_q;
  logic        drive;

  // First parameter table: erase, read modes and array density
  function automatic logic [7:0] fuid_param_byte(input logic [7:0] a);
    logic [7:0] v;
    v = fuid_pkg::UNUSED_BYTE;
    case (a)
      8'h30: v = 8'he5;
      8'h31: v = 8'h20;
      8'h32: v = 8'hf1;
      8'h33: v = 8'hff;
      8'h34: v = fuid_pkg::DENSITY_BITS_M1[7:0];
      8'h35: v = fuid_pkg::DENSITY_BITS_M1[15:8];
      8'h36: v = fuid_pkg::DENSITY_BITS_M1[23:16];
      8'h37: v = fuid_pkg::DENSITY_BITS_M1[31:24];
      8'h38: v = 8'h44;
      8'h39: v = 8'heb;
      8'h3a: v = 8'h08;
      8'h3b: v = 8'h6b;
      default: v = fuid_pkg::UNUSED_BYTE;
    endcase
    return v;
  endfunction

  // Fixed table; anything outside the decoded bytes reads as unused
  function automatic logic [7:0] fuid_table(input logic [23:0] a, input logic [7:0] maker);
    logic [7:0] v;
    v = fuid_pkg::UNUSED_BYTE;
    if (a[23:8] == 16'h0000) begin
      case (a[7:0])
        8'h00: v = 8'h53;
        8'h01: v = 8'h46;
        8'h02: v = 8'h44;
        8'h03: v = 8'h50;
        8'h04: v = 8'h00;
        8'h05: v = 8'h01;
        8'h06: v = 8'h01;
        8'h07: v = fuid_pkg::UNUSED_BYTE;
        8'h08: v = 8'h00;
        8'h09: v = 8'h00;
        8'h0a: v = 8'h01;
        8'h0b: v = fuid_pkg::STD_TABLE_DWORDS;
        8'h0c: v = fuid_pkg::STD_TABLE_PTR[7:0];
        8'h0d: v = fuid_pkg::STD_TABLE_PTR[15:8];
        8'h0e: v = fuid_pkg::STD_TABLE_PTR[23:16];
        8'h0f: v = fuid_pkg::UNUSED_BYTE;
        8'h10: v = maker;
        8'h11: v = 8'h00;
        8'h12: v = 8'h01;
        8'h13: v = fuid_pkg::VENDOR_TABLE_DWORDS;
        8'h14: v = fuid_pkg::VENDOR_TABLE_PTR[7:0];
        8'h15: v = fuid_pkg::VENDOR_TABLE_PTR[15:8];
        8'h16: v = fuid_pkg::VENDOR_TABLE_PTR[23:16];
        8'h17: v = fuid_pkg::UNUSED_BYTE;
        default: v = fuid_param_byte(a[7:0]);
      endcase
    end
    return v;
  endfunction

  wire [7:0] rx_byte   = {shift_in[6:0], link.si};
  wire       byte_end  = (bit_cnt == 3'd7);
  wire [7:0] tbl_byte  = fuid_table(tbl_addr, MAKER_CODE);
  // Identifier is a parameter constant; no command path writes it
  wire       uid_bit   = UNIQUE_ID[7'd127 - uid_idx];

  // Frame decoding kept out of the clocked processes
  wire       cmd_uid    = (rx_byte == fuid_pkg::UNIQUE_ID_READ_CMD);
  wire       cmd_table  = (rx_byte == fuid_pkg::DISCOVERY_TABLE_READ_CMD);
  wire       addr_last  = (byte_cnt == 2'(fuid_pkg::DISC_ADDR_BYTES - 1));
  wire [1:0] dummy_end  = is_uid ? 2'(fuid_pkg::UID_DUMMY_BYTES - 1) : 2'(fuid_pkg::DISC_DUMMY_BYTES - 1);
  wire       dummy_last = (byte_cnt == dummy_end);
  wire       uid_last   = (uid_idx == 7'(fuid_pkg::UID_BITS - 1));
  wire       in_data    = (state == FUID_DATA);
  // The table is looked up once per byte slot, on its first falling edge
  wire       load_byte  = (bit_cnt == 3'd0);

  // Input side on rising edge; chip select high clears the frame
  // Chip select only ever clears state here, so its timing against sck is relaxed
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      state    <= FUID_CMD;
      bit_cnt  <= 3'd0;
      shift_in <= 8'h00;
      byte_cnt <= 2'd0;
      is_uid   <= 1'b0;
      tbl_addr <= 24'h00_0000;
      uid_idx  <= 7'd0;
    end else begin
      bit_cnt  <= bit_cnt + 3'd1;
      shift_in <= rx_byte;
      case (state)
        FUID_CMD: begin
          if (byte_end) begin
            byte_cnt <= 2'd0;
            if (cmd_uid) begin
              is_uid <= 1'b1;
              state  <= FUID_DUMMY;
            end else if (cmd_table) begin
              state <= FUID_ADDR;
            end else begin
              state <= FUID_IGNORE;
            end
          end
        end
        FUID_ADDR: begin
          if (byte_end) begin
            tbl_addr <= {tbl_addr[15:0], rx_byte};
            byte_cnt <= byte_cnt + 2'd1;
            if (addr_last) begin
              byte_cnt <= 2'd0;
              state    <= FUID_DUMMY;
            end
          end
        end
        FUID_DUMMY: begin
          if (byte_end) begin
            byte_cnt <= byte_cnt + 2'd1;
            if (dummy_last) begin
              state <= FUID_DATA;
            end
          end
        end
        FUID_DATA: begin
          if (is_uid) begin
            uid_idx <= uid_idx + 7'd1;
            if (uid_last) begin
              state <= FUID_IGNORE;
            end
          end else if (byte_end) begin
            tbl_addr <= tbl_addr + 24'd1;
          end
        end
        FUID_IGNORE: state <= FUID_IGNORE;
        default:     state <= FUID_IGNORE;
      endcase
    end
  end

  // Output side on falling edge so data is stable at the host's rising edge
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_q     <= 1'b0;
      drive    <= 1'b0;
      out_byte <= 8'h00;
    end else begin
      drive <= in_data;
      if (in_data) begin
        if (is_uid) begin
          so_q <= uid_bit;
        end else if (load_byte) begin
          so_q     <= tbl_byte[7];
          out_byte <= {tbl_byte[6:0], 1'b0};
        end else begin
          so_q     <= out_byte[7];
          out_byte <= {out_byte[6:0], 1'b0};
        end
      end
    end
  end

  assign link.so    = so_q;
  assign link.so_oe = drive & ~link.cs_n;
endmodule

// ---- src/fuid_host.sv ----
// Host controller: APB registers order one id or table read over the link.
// The serial clock is divided from pclk; returned bytes land in data words.
`timescale 1ns/1ns
module fuid_host #(
  parameter int HALF_DIV  = fuid_pkg::SCK_HALF_DIV,
  parameter int MAX_BYTES = fuid_pkg::MAX_READ_BYTES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  fuid_if.host             link
);
  typedef enum {FUH_IDLE, FUH_SHIFT, FUH_END} fuh_state_t;

  fuh_state_t         state;
  logic               mode_table;
  logic [4:0]         rd_len;
  logic [23:0]        addr;
  logic               done;
  logic [7:0]         rx_data [MAX_BYTES];
  logic [7:0]         hdiv;
  logic               sck;
  logic               cs_n;
  logic [9:0]         bit_no;
  logic [9:0]         total_bits;
  logic [39:0]        tx_shift;
  logic [7:0]         rx_shift;
  logic [1:0]         so_s1;
  logic [1:0]         so_s2;
  logic [31:0]        rd_mux;

  wire wr_en  = psel & penable & pwrite;
  wire start  = wr_en && paddr == fuid_pkg::REG_CTRL && pwdata[fuid_pkg::CTRL_START_BIT] && state == FUH_IDLE;
  wire tick   = (hdiv == 8'(HALF_DIV - 1));
  wire rise   = tick & ~sck & (state == FUH_SHIFT);
  wire fall   = tick &  sck & (state == FUH_SHIFT);
  wire [3:0]  data_idx = 4'(bit_no[9:3] - 7'd5);
  wire        in_data  = (bit_no >= 10'd40);
  wire        data_reg = (paddr >= fuid_pkg::REG_DATA0) && (paddr < 8'(fuid_pkg::REG_DATA0 + 8'd16));
  wire [1:0]  word_sel = 2'(paddr[3:2]);
  wire [7:0]  ctrl_len = pwdata[fuid_pkg::CTRL_LEN_LSB +: 8];
  // Mode and length come from the same write that starts the frame
  wire        start_mode = pwdata[fuid_pkg::CTRL_MODE_BIT];
  wire [4:0]  start_len  = (ctrl_len == 8'd0 || ctrl_len > 8'(MAX_BYTES)) ? 5'(MAX_BYTES) : 5'(ctrl_len);
  // The line counts only while the device drives it
  wire        so_rx      = so_s2[1] & so_s2[0];

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == fuid_pkg::REG_CTRL) begin
      rd_mux = {19'h0, rd_len, 6'h0, mode_table, 1'b0};
    end else if (paddr == fuid_pkg::REG_ADDR) begin
      rd_mux = {8'h00, addr};
    end else if (paddr == fuid_pkg::REG_STATUS) begin
      rd_mux = {30'h0, done, state != FUH_IDLE};
    end else if (data_reg) begin
      rd_mux = {rx_data[{word_sel, 2'd3}], rx_data[{word_sel, 2'd2}],
                rx_data[{word_sel, 2'd1}], rx_data[{word_sel, 2'd0}]};
    end
  end

  // Read data is captured in the setup cycle so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Line and enable from the device's domain pass two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      so_s1 <= 2'b00;
      so_s2 <= 2'b00;
    end else begin
      so_s1 <= {link.so_oe, link.so};
      so_s2 <= so_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_table <= 1'b0;
      rd_len     <= 5'd1;
      addr       <= 24'h00_0000;
    end else if (wr_en && state == FUH_IDLE) begin
      if (paddr == fuid_pkg::REG_CTRL) begin
        mode_table <= start_mode;
        rd_len     <= start_len;
      end else if (paddr == fuid_pkg::REG_ADDR) begin
        addr <= pwdata[23:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= FUH_IDLE;
      done       <= 1'b0;
      hdiv       <= 8'h00;
      sck        <= 1'b0;
      cs_n       <= 1'b1;
      bit_no     <= 10'd0;
      total_bits <= 10'd0;
      tx_shift   <= 40'h0;
      rx_shift   <= 8'h00;
    end else begin
      hdiv <= tick ? 8'h00 : hdiv + 8'h01;
      case (state)
        FUH_IDLE: begin
          if (start) begin
            state  <= FUH_SHIFT;
            done   <= 1'b0;
            cs_n   <= 1'b0;
            bit_no <= 10'd0;
            // Both commands take 40 clocks before data: 8 + 24 + 8 or 8 + 32
            total_bits <= 10'd40 + {2'b00, (start_mode ? start_len : 5'(MAX_BYTES)), 3'b000};
            tx_shift   <= start_mode ? {fuid_pkg::DISCOVERY_TABLE_READ_CMD, addr, 8'h00}
                                     : {fuid_pkg::UNIQUE_ID_READ_CMD, 32'h0};
          end
        end
        FUH_SHIFT: begin
          if (rise) begin
            sck <= 1'b1;
          end else if (fall) begin
            sck      <= 1'b0;
            tx_shift <= {tx_shift[38:0], 1'b0};
            bit_no   <= bit_no + 10'd1;
            if (bit_no + 10'd1 == total_bits) begin
              state <= FUH_END;
            end
          end
          // Sample late in the high phase, after the sync delay has settled
          if (fall && in_data) begin
            rx_shift <= {rx_shift[6:0], so_rx};
            if (bit_no[2:0] == 3'd7) begin
              rx_data[data_idx] <= {rx_shift[6:0], so_rx};
            end
          end
        end
        FUH_END: begin
          if (tick) begin
            cs_n  <= 1'b1;
            done  <= 1'b1;
            state <= FUH_IDLE;
          end
        end
        default: state <= FUH_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n;
  assign link.sck  = sck;
  assign link.si   = tx_shift[39];
endmodule

// ---- test/fuid_props.sv ----
// Checker for the serial link between the id responder and its host.
// Assumes sck and cs_n are registered on pclk, so pclk sampling sees every sck phase.
`timescale 1ns/1ns
module fuid_props #(
  parameter logic [127:0] UNIQUE_ID = fuid_pkg::UID_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic       sck_q;
  logic [8:0] edge_cnt;
  logic [7:0] opc;
  wire        sck_rise = sck & ~sck_q;
  wire        is_uid   = (opc == fuid_pkg::UNIQUE_ID_READ_CMD);
  wire        is_table = (opc == fuid_pkg::DISCOVERY_TABLE_READ_CMD);
  wire        in_data  = is_uid ? (edge_cnt <= 9'd168) : is_table;

  // Rising sck edges counted per frame; chip select high clears the count and the opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q    <= 1'b0;
      edge_cnt <= 9'h000;
      opc      <= 8'h00;
    end else begin
      sck_q    <= sck;
      edge_cnt <= cs_n ? 9'h000 : edge_cnt + {8'h00, sck_rise};
      opc      <= cs_n ? 8'h00 : ((sck_rise && edge_cnt < 9'd8) ? {opc[6:0], si} : opc);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_oe_idle;     cs_n |-> !so_oe; endproperty
  property p_sck_idle;    cs_n |-> !sck; endproperty
  property p_hdr_quiet;   so_oe |-> edge_cnt >= 9'd40; endproperty
  property p_opcode;      so_oe |-> (is_uid || is_table); endproperty
  // Bit 127-k of the id is on the line at the rise that follows 40 header clocks plus k
  property p_uid_bits;    (sck_rise && so_oe && is_uid) |-> so == UNIQUE_ID[9'd167 - edge_cnt]; endproperty
  property p_uid_release; (is_uid && edge_cnt >= 9'd168 && !sck) |-> !so_oe; endproperty
  property p_data_drive;  (!cs_n && sck && !sck_rise && edge_cnt >= 9'd41 && in_data) |-> so_oe; endproperty
  property p_so_stable;   (so_oe && sck && !sck_rise) |-> $stable(so); endproperty

  a_oe_idle:     assert property (p_oe_idle) else $error("output enabled while deselected");
  a_sck_idle:    assert property (p_sck_idle) else $error("serial clock moves outside a frame");
  a_hdr_quiet:   assert property (p_hdr_quiet) else $error("output driven during command header");
  a_opcode:      assert property (p_opcode) else $error("output driven for an unknown opcode");
  a_uid_bits:    assert property (p_uid_bits) else $error("wrong id bit on the line");
  a_uid_release: assert property (p_uid_release) else $error("output held after 128 id bits");
  a_data_drive:  assert property (p_data_drive) else $error("output not driven in data phase");
  a_so_stable:   assert property (p_so_stable) else $error("output changed while sck high");

  c_uid:   cover property (is_uid && edge_cnt == 9'd168);
  c_table: cover property (is_table && edge_cnt == 9'd168);
  c_abort: cover property (cs_n && $past(so_oe));
endmodule

// ---- test/fuid_tb.sv ----
// Self-checking bench: host and responder joined by the link, driven over APB.
// Assumes the zero-wait APB slave and register map of the host controller.
`timescale 1ns/1ns
module fuid_tb;
  localparam logic [127:0] UID   = 128'h5a5a_0f1e_2d3c_4b69_7887_96a5_b4c3_d2e1; // Arbitrary
  localparam logic [7:0]   MAKER = 8'h3c; // Arbitrary

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] words [4];
  int          num_errors;
  int          tests_run;

  fuid_if link_bus();
  fuid_host i_fuid_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                         .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                         .link(link_bus.host));
  fuid_dev #(.UNIQUE_ID(UID), .MAKER_CODE(MAKER)) i_fuid_dev (.link(link_bus.dev));
  fuid_props #(.UNIQUE_ID(UID)) i_fuid_props (.pclk(pclk), .presetn(presetn), .cs_n(link_bus.cs_n),
                         .sck(link_bus.sck), .si(link_bus.si), .so(link_bus.so), .so_oe(link_bus.so_oe));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    check("slave error", {31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for done, then collects the four data words
  task automatic wait_done();
    logic [31:0] q;
    int          n;
    n = 0;
    do begin
      apb_xfer(1'b0, fuid_pkg::REG_STATUS, 32'h0, q);
      n++;
    end while (q[fuid_pkg::STATUS_DONE_BIT] !== 1'b1 && n < 3000);
    check("done", {31'h0, q[fuid_pkg::STATUS_DONE_BIT]}, 32'h1);
    for (int w = 0; w < 4; w++)
      apb_xfer(1'b0, fuid_pkg::REG_DATA0 + 8'(4 * w), 32'h0, words[w]);
  endtask

  task automatic start_read(input logic mode, input int len, input logic [23:0] addr);
    logic [31:0] q;
    apb_xfer(1'b1, fuid_pkg::REG_ADDR, {8'h00, addr}, q);
    apb_xfer(1'b1, fuid_pkg::REG_CTRL, (32'(len) << fuid_pkg::CTRL_LEN_LSB) |
             (32'(mode) << fuid_pkg::CTRL_MODE_BIT) | (32'h1 << fuid_pkg::CTRL_START_BIT), q);
  endtask

  function automatic logic [7:0] tbl(input int a);
    case (a)
      'h00: return 8'h53;  'h01: return 8'h46;  'h02: return 8'h44;  'h03: return 8'h50;
      'h04, 'h08, 'h09, 'h0d, 'h0e, 'h11, 'h15, 'h16: return 8'h00;
      'h05, 'h06, 'h0a, 'h12: return 8'h01;
      'h0b: return 8'h09;  'h0c: return 8'h30;  'h10: return MAKER;  'h13: return 8'h03;
      'h14: return 8'h60;  'h30: return 8'he5;  'h31: return 8'h20;  'h32: return 8'hf1;
      'h37: return 8'h01;  'h38: return 8'h44;  'h39: return 8'heb;  'h3a: return 8'h08;
      'h3b: return 8'h6b;
      default: return 8'hff;
    endcase
  endfunction

  task automatic t_reset();
    logic [31:0] q;
    apb_xfer(1'b0, fuid_pkg::REG_STATUS, 32'h0, q);
    check("status after reset", q, 32'h0);
    apb_xfer(1'b0, 8'h40, 32'h0, q);
    check("unmapped read", q, 32'h0);
  endtask

  // Two id reads must return the same fixed value, first byte from bits 127:120
  task automatic t_uid();
    for (int r = 0; r < 2; r++) begin
      start_read(1'b0, 16, 24'h0);
      wait_done();
      for (int j = 0; j < 16; j++)
        check("id byte", {24'h0, words[j / 4][8 * (j % 4) +: 8]}, {24'h0, UID[127 - 8 * j -: 8]});
    end
  endtask

  // Short reads stop mid-table; odd starts cross header and reserved bytes
  task automatic t_table();
    int starts [6] = '{'h00, 'h10, 'h30, 'h06, 'h2e, 'h05};
    int lens   [6] = '{16, 8, 12, 3, 16, 1};
    for (int s = 0; s < 6; s++) begin
      start_read(1'b1, lens[s], 24'(starts[s]));
      wait_done();
      for (int j = 0; j < lens[s]; j++)
        check("table byte", {24'h0, words[j / 4][8 * (j % 4) +: 8]}, {24'h0, tbl(starts[s] + j)});
    end
  endtask

  // An address written while busy is ignored and the read keeps its own
  task automatic t_busy();
    logic [31:0] q;
    start_read(1'b1, 4, 24'h000038);
    apb_xfer(1'b1, fuid_pkg::REG_ADDR, 32'h0, q);
    wait_done();
    apb_xfer(1'b0, fuid_pkg::REG_ADDR, 32'h0, q);
    check("address kept while busy", q, 32'h0000_0038);
    apb_xfer(1'b0, fuid_pkg::REG_CTRL, 32'h0, q);
    check("control readback", q, (32'h4 << fuid_pkg::CTRL_LEN_LSB) | (32'h1 << fuid_pkg::CTRL_MODE_BIT));
    check("busy read data", words[0], 32'h6b08_eb44);
  endtask

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    num_errors = 0;
    tests_run  = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_uid();
    t_table();
    t_busy();
    end_of_test();
  end

  // A read frame takes under a thousand cycles; this bound covers all nine of them four times over
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end
endmodule
